// >>> logic/smpf_supply_monitor.sv
// module: power-fail reset control for a digital and an analog supply monitor
`timescale 1ns/10ps
module smpf_supply_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic por_event,
    input wire smpf_pkg::smpf_cmp_s dig_cmp,
    input wire smpf_pkg::smpf_cmp_s ana_cmp,
    input wire logic sleep_mode,
    input wire smpf_pkg::smpf_reg_req_s reg_req,
    input wire logic flash_op,
    input wire logic power_fail_flag_clr,
    output logic [7:0] reg_rdata,
    output logic core_reset,
    output logic reset_pin_n,
    output logic power_fail_reset_flag,
    output logic ram_invalid,
    output logic flash_error_reset,
    output logic supply_warn_irq
);
    // ----------------------------------------------------------------
    // synchroniser bit positions and address decode
    // ----------------------------------------------------------------
    localparam int DIG_RST_IDX = 3;
    localparam int DIG_WARN_IDX = 2;
    localparam int ANA_RST_IDX = 1;
    localparam int ANA_WARN_IDX = 0;

    // one compare shared by the write and the read path
    function automatic logic hits_ctrl(input logic [7:0] addr);
        return addr == smpf_pkg::SUPPLY_MONITOR_CONTROL_ADDR;
    endfunction

    // ----------------------------------------------------------------
    // comparator synchronisers
    // ----------------------------------------------------------------
    logic [3:0] cmp_meta_ff;
    logic [3:0] cmp_sync_ff;
    logic [3:0] nxt_cmp_sync;

    // second stage only reads the first; everything else reads the second
    always_comb begin
        nxt_cmp_sync = cmp_meta_ff;
    end

    // reset to supply-good: a general reset must not fake a warning or hold the core
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmp_meta_ff <= '1;
            cmp_sync_ff <= '1;
        end else begin
            cmp_meta_ff <= {dig_cmp.above_rst, dig_cmp.above_warn,
                            ana_cmp.above_rst, ana_cmp.above_warn};
            cmp_sync_ff <= nxt_cmp_sync;
        end
    end

    // ----------------------------------------------------------------
    // monitor settings, kept across all but power-on/power-fail reset
    // ----------------------------------------------------------------
    smpf_pkg::smpf_mon_cfg_s dig_cfg_ff;
    smpf_pkg::smpf_mon_cfg_s ana_cfg_ff;
    smpf_pkg::smpf_mon_cfg_s nxt_dig_cfg;
    smpf_pkg::smpf_mon_cfg_s nxt_ana_cfg;
    logic ctrl_wr;
    logic pf_flag_ff;
    logic nxt_pf_flag;
    logic warn_seen_ff;
    logic nxt_warn_seen;
    logic warn_irq_en_ff;
    logic nxt_warn_irq_en;
    logic dig_mon_hold;
    logic ana_mon_hold;
    logic dig_below;
    logic ana_below;

    assign ctrl_wr = reg_req.wr && hits_ctrl(reg_req.addr);

    // software writes; rst (other resets) never touches these
    always_comb begin
        nxt_dig_cfg = dig_cfg_ff;
        nxt_ana_cfg = ana_cfg_ff;
        nxt_warn_irq_en = warn_irq_en_ff;
        if (ctrl_wr) begin
            nxt_dig_cfg.enable = reg_req.wdata[smpf_pkg::DIG_EN_BIT];
            nxt_dig_cfg.reset_sel = reg_req.wdata[smpf_pkg::DIG_SEL_BIT];
            nxt_ana_cfg.enable = reg_req.wdata[smpf_pkg::ANA_EN_BIT];
            nxt_ana_cfg.reset_sel = reg_req.wdata[smpf_pkg::ANA_SEL_BIT];
            // writing a one to the digital warn bit arms the warning interrupt
            nxt_warn_irq_en = reg_req.wdata[smpf_pkg::DIG_WARN_BIT];
        end
    end

    // reset only by power-on/power-fail, so software resets keep settings
    always_ff @(posedge core_clk or posedge por_event) begin
        if (por_event) begin
            dig_cfg_ff <= '{enable: 1'b1, reset_sel: 1'b1};
            ana_cfg_ff <= '{enable: 1'b0, reset_sel: 1'b0};
            warn_irq_en_ff <= 1'b0;
        end else begin
            dig_cfg_ff <= nxt_dig_cfg;
            ana_cfg_ff <= nxt_ana_cfg;
            warn_irq_en_ff <= nxt_warn_irq_en;
        end
    end

    // ----------------------------------------------------------------
    // reset generation
    // ----------------------------------------------------------------
    // settings are never overwritten in sleep, only masked, so wake restores them
    assign dig_mon_hold = dig_cfg_ff.enable && dig_cfg_ff.reset_sel && !sleep_mode;
    assign ana_mon_hold = ana_cfg_ff.enable && ana_cfg_ff.reset_sel && !sleep_mode;

    // raw level asserts at once with no clock; release waits for the
    // synchronised level, so a comparator glitch cannot free the core early
    assign dig_below = !dig_cmp.above_rst || !cmp_sync_ff[DIG_RST_IDX];
    assign ana_below = !ana_cmp.above_rst || !cmp_sync_ff[ANA_RST_IDX];
    assign core_reset = (dig_mon_hold && dig_below)
                     || (ana_mon_hold && ana_below)
                     || por_event;
    assign reset_pin_n = !core_reset;

    // ----------------------------------------------------------------
    // power-fail flag and warning state
    // ----------------------------------------------------------------
    // flag sticks until software clears it; a new power-fail wins over the clear
    always_comb begin
        nxt_pf_flag = pf_flag_ff;
        if (power_fail_flag_clr) begin
            nxt_pf_flag = 1'b0;
        end
    end

    // latch a warning while the digital monitor is live; a set beats a clear
    always_comb begin
        nxt_warn_seen = warn_seen_ff;
        if (!cmp_sync_ff[DIG_WARN_IDX] && dig_cfg_ff.enable && !sleep_mode) begin
            nxt_warn_seen = 1'b1;
        end else if (ctrl_wr && !reg_req.wdata[smpf_pkg::DIG_OK_BIT]) begin
            nxt_warn_seen = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge por_event) begin
        if (por_event) begin
            pf_flag_ff <= 1'b1;
        end else begin
            pf_flag_ff <= nxt_pf_flag;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            warn_seen_ff <= 1'b0;
        end else begin
            warn_seen_ff <= nxt_warn_seen;
        end
    end

    assign power_fail_reset_flag = pf_flag_ff;
    assign ram_invalid = pf_flag_ff;
    assign supply_warn_irq = warn_seen_ff && warn_irq_en_ff;

    // ----------------------------------------------------------------
    // flash protection
    // ----------------------------------------------------------------
    // a flash operation without the digital monitor enabled resets the device
    assign flash_error_reset = flash_op && !dig_cfg_ff.enable;

    // ----------------------------------------------------------------
    // read data, registered
    // ----------------------------------------------------------------
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // ok bits are live levels per monitor; the digital warn bit shows the latched warning, the analog one the below-warning level
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_req.rd && hits_ctrl(reg_req.addr)) begin
            nxt_rdata = 8'h00;
            nxt_rdata[smpf_pkg::DIG_EN_BIT] = dig_cfg_ff.enable;
            nxt_rdata[smpf_pkg::DIG_SEL_BIT] = dig_cfg_ff.reset_sel;
            nxt_rdata[smpf_pkg::DIG_OK_BIT] = cmp_sync_ff[DIG_WARN_IDX];
            nxt_rdata[smpf_pkg::DIG_WARN_BIT] = warn_seen_ff;
            nxt_rdata[smpf_pkg::ANA_EN_BIT] = ana_cfg_ff.enable;
            nxt_rdata[smpf_pkg::ANA_SEL_BIT] = ana_cfg_ff.reset_sel;
            nxt_rdata[smpf_pkg::ANA_OK_BIT] = cmp_sync_ff[ANA_WARN_IDX];
            nxt_rdata[smpf_pkg::ANA_WARN_BIT] = !cmp_sync_ff[ANA_WARN_IDX];
        end else if (reg_req.rd) begin
            nxt_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
endmodule

// >>> logic/smpf_pkg.sv
// package: constants and carriers for the supply monitor power-fail reset block
package smpf_pkg;
    // ----------------------------------------------------------------
    // register map and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hff;
    localparam int DIG_EN_BIT = 7;
    localparam int DIG_SEL_BIT = 6;
    localparam int DIG_OK_BIT = 5;
    localparam int DIG_WARN_BIT = 4;
    localparam int ANA_EN_BIT = 3;
    localparam int ANA_SEL_BIT = 2;
    localparam int ANA_OK_BIT = 1;
    localparam int ANA_WARN_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'hc0;

    // one monitor's software settings
    typedef struct packed {
        logic enable;
        logic reset_sel;
    } smpf_mon_cfg_s;

    // one monitor's comparator levels (high = supply above threshold)
    typedef struct packed {
        logic above_rst;
        logic above_warn;
    } smpf_cmp_s;

    // one-port register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } smpf_reg_req_s;
endpackage

// >>> testbench/smpf_supply_model.sv
// model: comparator pair that watches one supply level
`timescale 1ns/10ps
module smpf_supply_model #(
    parameter logic [15:0] RST_MV = 16'h06a4,
    parameter logic [15:0] WARN_MV = 16'h0708
) (
    input wire logic [15:0] supply_mv,
    output smpf_pkg::smpf_cmp_s cmp
);
    // comparators switch at once, no hysteresis, so edges are sharp
    assign cmp.above_rst = supply_mv > RST_MV;
    assign cmp.above_warn = supply_mv > WARN_MV;
endmodule

// >>> testbench/smpf_supply_monitor_sva.sv
// checker: port-level assertions for the supply monitor block
`timescale 1ns/10ps
module smpf_supply_monitor_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic por_event,
    input wire smpf_pkg::smpf_cmp_s dig_cmp,
    input wire smpf_pkg::smpf_cmp_s ana_cmp,
    input wire logic sleep_mode,
    input wire logic flash_op,
    input wire logic power_fail_flag_clr,
    input wire logic core_reset,
    input wire logic reset_pin_n,
    input wire logic power_fail_reset_flag,
    input wire logic ram_invalid,
    input wire logic flash_error_reset
);
    // ----------------------------------------------------------------
    // assertions and covers
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_por_holds_core: assert property (por_event |-> core_reset && !reset_pin_n)
        else $error("core free during power-on reset");
    a_pin_follows_core: assert property (reset_pin_n == !core_reset)
        else $error("reset pin and core reset disagree");
    a_supply_up_free: assert property (
        (!por_event && dig_cmp.above_rst && ana_cmp.above_rst) [*3] |-> !core_reset)
        else $error("core held with supplies up");
    a_sleep_masks_reset: assert property (sleep_mode && !por_event |-> !core_reset)
        else $error("reset raised in sleep");
    a_flag_after_por: assert property ($fell(por_event) |-> power_fail_reset_flag)
        else $error("flag low after power-on reset");
    a_ram_flag_match: assert property (ram_invalid == power_fail_reset_flag)
        else $error("ram invalid differs from flag");
    a_flag_holds: assert property (!power_fail_flag_clr && !por_event ##1 !por_event
        |-> $stable(power_fail_reset_flag)) else $error("flag changed unasked");
    a_flash_needs_op: assert property (flash_error_reset |-> flash_op)
        else $error("flash error without flash access");
    c_core_held: cover property (core_reset && !por_event);
    c_flash_err: cover property (flash_error_reset);
    c_sleep_low: cover property (sleep_mode && !dig_cmp.above_rst);
endmodule
bind smpf_supply_monitor smpf_supply_monitor_chk smpf_supply_monitor_chk_inst (.core_clk, .rst,
    .por_event, .dig_cmp, .ana_cmp, .sleep_mode, .flash_op, .power_fail_flag_clr, .core_reset,
    .reset_pin_n, .power_fail_reset_flag, .ram_invalid, .flash_error_reset);

// >>> testbench/tb.sv
// testbench: register-level scenarios for the supply monitor block
`timescale 1ns/10ps
module tb;
    // ----------------------------------------------------------------
    // stimulus, models and checks
    // ----------------------------------------------------------------
    logic core_clk = 0, rst = 1, por_event = 1, sleep_mode = 0, flash_op = 0, pf_clr = 0;
    logic [15:0] dmv = 16'h0bb8, amv = 16'h0bb8;
    logic [7:0] rdata;
    logic core_reset, pin_n, pf_flag, ram_inv, fl_err, irq;
    smpf_pkg::smpf_cmp_s dcmp, acmp;
    smpf_pkg::smpf_reg_req_s req = '0;
    int mismatches = 0, n_compared = 0;
    always #5 core_clk = ~core_clk;
    smpf_supply_model smpf_supply_model_inst (.supply_mv(dmv), .cmp(dcmp));
    smpf_supply_model ana_supply_model_inst (.supply_mv(amv), .cmp(acmp));
    smpf_supply_monitor smpf_supply_monitor_inst (.core_clk(core_clk), .rst(rst),
        .por_event(por_event), .dig_cmp(dcmp), .ana_cmp(acmp), .sleep_mode(sleep_mode),
        .reg_req(req), .flash_op(flash_op), .power_fail_flag_clr(pf_clr), .reg_rdata(rdata),
        .core_reset(core_reset), .reset_pin_n(pin_n), .power_fail_reset_flag(pf_flag),
        .ram_invalid(ram_inv), .flash_error_reset(fl_err), .supply_warn_irq(irq));
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one-cycle strobes, released just after the taking edge
    task automatic wr(input logic [7:0] d);
        step(1);
        req = '{1'b1, 1'b0, smpf_pkg::SUPPLY_MONITOR_CONTROL_ADDR, d};
        step(1);
        req = '0;
    endtask
    task automatic rd(input logic [7:0] m, exp, input string what);
        step(1);
        req = '{1'b0, 1'b1, smpf_pkg::SUPPLY_MONITOR_CONTROL_ADDR, 8'h00};
        step(1);
        req = '0;
        chk(what, exp, rdata & m);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // a hang is cut long after the sequence should end
    initial begin
        #5000;
        mismatches++;
        print_verdict();
    end
    initial begin
        step(5);
        rst = 0;
        por_event = 0;
        chk("flag", 8'h01, pf_flag);
        chk("ram", 8'h01, ram_inv);
        rd(8'hcc, 8'hc0, "por cfg");
        // every input moves just after an edge; checks look one edge later
        dmv = 16'h03e8;
        step(1);
        chk("dig rst", 8'h01, core_reset);
        chk("pin", 8'h00, pin_n);
        dmv = 16'h0bb8;
        step(1);
        chk("release held", 8'h01, core_reset);
        step(1);
        chk("release", 8'h00, core_reset);
        wr(8'h00);
        dmv = 16'h03e8;
        flash_op = 1;
        step(1);
        chk("off no rst", 8'h00, core_reset);
        chk("flash err", 8'h01, fl_err);
        flash_op = 0;
        dmv = 16'h0bb8;
        step(1);
        rst = 1;
        step(1);
        rst = 0;
        rd(8'hcc, 8'h00, "sw rst cfg");
        chk("flag kept", 8'h01, pf_flag);
        wr(8'hcc);
        flash_op = 1;
        amv = 16'h03e8;
        step(1);
        chk("flash ok", 8'h00, fl_err);
        chk("ana rst", 8'h01, core_reset);
        flash_op = 0;
        sleep_mode = 1;
        dmv = 16'h03e8;
        step(1);
        chk("sleep", 8'h00, core_reset);
        step(2);
        rd(8'h10, 8'h00, "sleep warn");
        sleep_mode = 0;
        amv = 16'h0bb8;
        step(1);
        chk("wake rst", 8'h01, core_reset);
        dmv = 16'h0bb8;
        rd(8'hcc, 8'hcc, "wake cfg");
        step(3);
        wr(8'hd0);
        chk("no irq", 8'h00, irq);
        dmv = 16'h06d6;
        step(4);
        chk("irq", 8'h01, irq);
        chk("warn no rst", 8'h00, core_reset);
        rd(8'h33, 8'h12, "ok flags");
        pf_clr = 1;
        step(1);
        pf_clr = 0;
        chk("flag clr", 8'h00, pf_flag);
        por_event = 1;
        step(1);
        chk("por rst", 8'h01, core_reset);
        chk("por pin", 8'h00, pin_n);
        por_event = 0;
        chk("por flag", 8'h01, pf_flag);
        rd(8'hcc, 8'hc0, "por cfg2");
        print_verdict();
    end
endmodule
